/* hdl/asp_uart.sv */
// Asynchronous serial port with APB register access
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "asp_params.svh"

// Function
// - Async mode frames carry 8, 7 or 5 data bits from mode bits.
// - Parity bit optional, one or two end bits; some combos prohibited.
// - Clock source: internal, internal with bit clock out, external 16x.
// - Clearing transmit enable sets the transmit-buffer-empty flag.
// - Clearing receive enable leaves receive flags and holding data.
// - Buffer-empty flag at 0 moves holding register into shifter.
// - After the move, set buffer-empty, start sending, request irq.
// - Buffer-empty 0 at end bit: load next, chain next frame.
// - Buffer-empty 1 at end bit: set done, hold line high, irq.
// - Detect start bit, shift data in, check parity and end bit.
// - Parity check counts ones against odd or even select.
// - Check end bit is 1; with two, only the first.
// - Frame with receive-full set: overrun, data dropped, error irq.
// - Parity mismatch sets flag, data still stored, error irq.
// - End bit 0 sets framing flag, data stored, error irq.
// - Clean frame stores data, sets receive-full, full irq.
// - Errors keep receive-full; all matching flags set together.
// - No reception while any receive error flag is set.
// - Reading receive holding register clears receive-full.
module asp_uart (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line
  input wire logic rx_line_pin,
  output logic tx_line_pin,
  // Serial clock pin
  input wire logic serial_clk_pin_in,
  output asp_pkg::asp_pin_drv_t serial_clk_pin,
  // Interrupt requests
  output asp_pkg::asp_irq_t irq
);
  import asp_pkg::*;

  // ========================================================
  // Helpers
  // Data length from mode bits; prohibited short-without-parity runs 7 or 8 per the seven bit
  function automatic logic [3:0] data_len(input logic [7:0] m);
    if (m[`ASP_M_SHORT] && m[`ASP_M_PAR_ON]) begin
      data_len = 4'h5;
    end else if (m[`ASP_M_SEVEN]) begin
      data_len = 4'h7;
    end else begin
      data_len = 4'h8;
    end
  endfunction : data_len

  // Parity over the valid data bits, inverted for odd
  function automatic logic par_of(input logic [7:0] d, input logic [3:0] n,
                                  input logic odd);
    logic [7:0] mask;
    mask = 8'hff >> (4'h8 - n);
    par_of = (^(d & mask)) ^ odd;
  endfunction : par_of

  // ========================================================
  // Registers and flags
  logic [7:0] mode_reg;
  logic [7:0] control_reg;
  logic [7:0] baud_div;
  logic [7:0] tx_holding;
  logic [7:0] rx_holding;
  logic tx_buf_empty;
  logic rx_buf_full;
  logic overrun_flag;
  logic framing_flag;
  logic parity_err_flag;
  logic tx_done_flag;
  logic [7:0] status_reg;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [3:0] nbits;

  assign status_reg = {tx_buf_empty, rx_buf_full, overrun_flag,
                       framing_flag, parity_err_flag, tx_done_flag, 2'b00};
  assign nbits = data_len(mode_reg);

  // APB: zero-wait slave, unmapped addresses answer with pslverr
  assign addr_ok = (paddr == `ASP_MODE_OFS) || (paddr == `ASP_CTRL_OFS) ||
                   (paddr == `ASP_STAT_OFS) || (paddr == `ASP_TXH_OFS) ||
                   (paddr == `ASP_RXH_OFS) || (paddr == `ASP_BAUD_OFS);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && penable && !pwrite && addr_ok;

  // Read data latched in setup phase so it is a flop output
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      unique case (paddr)
        `ASP_MODE_OFS: prdata <= {24'h00_0000, mode_reg};
        `ASP_CTRL_OFS: prdata <= {24'h00_0000, control_reg};
        `ASP_STAT_OFS: prdata <= {24'h00_0000, status_reg};
        `ASP_TXH_OFS: prdata <= {24'h00_0000, tx_holding};
        `ASP_RXH_OFS: prdata <= {24'h00_0000, rx_holding};
        `ASP_BAUD_OFS: prdata <= {24'h00_0000, baud_div};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Plain software-written registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= `ASP_MODE_RST;
      control_reg <= `ASP_CTRL_RST;
      baud_div <= `ASP_BAUD_RST;
      tx_holding <= 8'h00;
    end else if (wr_en) begin
      unique case (paddr)
        `ASP_MODE_OFS: mode_reg <= pwdata[7:0];
        `ASP_CTRL_OFS: control_reg <= pwdata[7:0];
        `ASP_BAUD_OFS: baud_div <= pwdata[7:0];
        `ASP_TXH_OFS: tx_holding <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  logic tx_on;
  logic rx_on;
  logic stat_wr;
  logic txh_wr;
  assign tx_on = control_reg[`ASP_C_TX_ON];
  assign rx_on = control_reg[`ASP_C_RX_ON];
  assign stat_wr = wr_en && (paddr == `ASP_STAT_OFS);
  assign txh_wr = wr_en && (paddr == `ASP_TXH_OFS);

  // ========================================================
  // Clock source and 16x tick
  logic [1:0] clk_src;
  logic async_ok;
  logic [7:0] div_cnt;
  logic ck_s1, ck_s2, ck_s3;
  logic tick;
  logic [3:0] bitclk_cnt;
  assign clk_src = {control_reg[`ASP_C_SRC_HI], control_reg[`ASP_C_SRC_LO]};
  // Only asynchronous framing is built; synchronous mode gets no tick, so no bit ever completes
  assign async_ok = !mode_reg[`ASP_M_SYNC] && (clk_src != 2'b11);

  // External clock pin passes two flops before edge detection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
    end else begin
      ck_s1 <= serial_clk_pin_in;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
    end
  end

  // Internal divider runs free so the bit rate is steady
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 8'h00;
    end else if (div_cnt >= baud_div) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end

  always_comb begin
    tick = 1'b0;
    if (async_ok) begin
      if (clk_src[1]) begin
        tick = ck_s2 && !ck_s3;
      end else begin
        tick = (div_cnt >= baud_div);
      end
    end
  end

  // Bit-rate clock out: one period per sixteen ticks
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bitclk_cnt <= 4'h0;
    end else if (tick) begin
      bitclk_cnt <= bitclk_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      serial_clk_pin <= '{out: 1'b1, oe_n: 1'b1};
    end else begin
      serial_clk_pin.out <= bitclk_cnt[3];
      serial_clk_pin.oe_n <= !(async_ok && clk_src == 2'b01);
    end
  end

  // ========================================================
  // Transmitter
  asp_tx_st_t tx_st;
  logic [7:0] tx_shifter;
  logic [3:0] tx_tcnt;
  logic [3:0] tx_idx;
  logic tx_par;
  logic tx_chain;
  logic tx_bit_end;
  logic tx_end_chk;
  logic tx_take;
  logic tx_end_evt;
  assign tx_bit_end = tick && (tx_tcnt == `ASP_OVS_LAST);
  // Buffer-empty is sampled on the first tick of the first end bit
  assign tx_end_chk = (tx_st == TX_END) && tick && (tx_tcnt == 4'h0) &&
                      (tx_idx == 4'h0);
  assign tx_take = tx_on && !tx_buf_empty &&
                   ((tx_st == TX_IDLE) || tx_end_chk);
  assign tx_end_evt = tx_on && tx_buf_empty && tx_end_chk;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_st <= TX_IDLE;
      tx_line_pin <= 1'b1;
      tx_shifter <= 8'h00;
      tx_tcnt <= 4'h0;
      tx_idx <= 4'h0;
      tx_par <= 1'b0;
      tx_chain <= 1'b0;
    end else if (!tx_on) begin
      tx_st <= TX_IDLE;
      tx_line_pin <= 1'b1;
      tx_chain <= 1'b0;
    end else begin
      if (tick) begin
        tx_tcnt <= tx_tcnt + 4'h1;
      end
      if (tx_take) begin
        tx_shifter <= tx_holding;
        tx_par <= par_of(tx_holding, nbits,
                         mode_reg[`ASP_M_PAR_ODD]);
      end
      unique case (tx_st)
        TX_IDLE: begin
          tx_line_pin <= 1'b1;
          if (tx_take) begin
            tx_st <= TX_START;
            tx_line_pin <= 1'b0;
            tx_tcnt <= 4'h0;
          end
        end
        TX_START: begin
          if (tx_bit_end) begin
            tx_st <= TX_DATA;
            tx_idx <= 4'h0;
            tx_line_pin <= tx_shifter[0];
          end
        end
        TX_DATA: begin
          if (tx_bit_end) begin
            tx_idx <= tx_idx + 4'h1;
            tx_line_pin <= tx_shifter[tx_idx[2:0] + 3'h1];
            if (tx_idx == nbits - 4'h1) begin
              tx_idx <= 4'h0;
              if (mode_reg[`ASP_M_PAR_ON]) begin
                tx_st <= TX_PAR;
                tx_line_pin <= tx_par;
              end else begin
                tx_st <= TX_END;
                tx_line_pin <= 1'b1;
              end
            end
          end
        end
        TX_PAR: begin
          if (tx_bit_end) begin
            tx_st <= TX_END;
            tx_line_pin <= 1'b1;
          end
        end
        TX_END: begin
          if (tx_end_chk) begin
            tx_chain <= !tx_buf_empty;
          end
          if (tx_bit_end) begin
            if (tx_idx == 4'h0 && mode_reg[`ASP_M_TWO_END]) begin
              tx_idx <= 4'h1;
            end else if (tx_chain) begin
              tx_st <= TX_START;
              tx_line_pin <= 1'b0;
              tx_idx <= 4'h0;
            end else begin
              tx_st <= TX_IDLE;
              tx_idx <= 4'h0;
            end
          end
        end
      endcase
    end
  end

  // Buffer-empty and done flags; hardware set wins over software clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_buf_empty <= 1'b1;
      tx_done_flag <= 1'b1;
    end else begin
      if (!tx_on || tx_take) begin
        tx_buf_empty <= 1'b1;
      end else if (txh_wr) begin
        tx_buf_empty <= 1'b0;
      end
      if (tx_end_evt) begin
        tx_done_flag <= 1'b1;
      end else if (txh_wr) begin
        tx_done_flag <= 1'b0;
      end
    end
  end

  // ========================================================
  // Receiver
  asp_rx_st_t rx_st;
  logic rx_s1, rx_s2;
  logic [7:0] rx_shifter;
  logic [3:0] rx_tcnt;
  logic [3:0] rx_idx;
  logic rx_par_bit;
  logic rx_fin;
  logic rx_errs;
  logic [7:0] rx_data;
  logic par_bad;
  logic rx_mid;
  assign rx_errs = overrun_flag || framing_flag || parity_err_flag;
  assign rx_mid = tick && (rx_tcnt == `ASP_OVS_LAST);
  // Only the first end bit is looked at; a disabled receiver ends nothing
  assign rx_fin = rx_on && (rx_st == RX_END) && rx_mid;
  assign rx_data = rx_shifter >> (4'h8 - nbits);
  assign par_bad = mode_reg[`ASP_M_PAR_ON] &&
                   (rx_par_bit != par_of(rx_data, nbits,
                                         mode_reg[`ASP_M_PAR_ODD]));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= rx_line_pin;
      rx_s2 <= rx_s1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_st <= RX_IDLE;
      rx_shifter <= 8'h00;
      rx_tcnt <= 4'h0;
      rx_idx <= 4'h0;
      rx_par_bit <= 1'b0;
    end else if (!rx_on) begin
      rx_st <= RX_IDLE;
    end else begin
      if (tick) begin
        rx_tcnt <= rx_tcnt + 4'h1;
      end
      unique case (rx_st)
        RX_IDLE: begin
          if (tick && !rx_s2 && !rx_errs) begin
            rx_st <= RX_START;
            rx_tcnt <= 4'h0;
          end
        end
        RX_START: begin
          if (tick && rx_tcnt == `ASP_MID_START) begin
            // Realigning here puts every later sample at mid-bit
            rx_tcnt <= 4'h0;
            rx_idx <= 4'h0;
            rx_st <= rx_s2 ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_mid) begin
            rx_shifter <= {rx_s2, rx_shifter[7:1]};
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx == nbits - 4'h1) begin
              rx_st <= mode_reg[`ASP_M_PAR_ON] ? RX_PAR : RX_END;
            end
          end
        end
        RX_PAR: begin
          if (rx_mid) begin
            rx_par_bit <= rx_s2;
            rx_st <= RX_END;
          end
        end
        RX_END: begin
          if (rx_mid) begin
            rx_st <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Receive flags and holding register; set wins over clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_holding <= 8'h00;
      rx_buf_full <= 1'b0;
      overrun_flag <= 1'b0;
      framing_flag <= 1'b0;
      parity_err_flag <= 1'b0;
    end else begin
      if (rx_fin && !rx_buf_full) begin
        rx_holding <= rx_data;
      end
      if (rx_fin && !rx_buf_full && rx_s2 && !par_bad) begin
        rx_buf_full <= 1'b1;
      end else if ((rd_en && paddr == `ASP_RXH_OFS) ||
                   (stat_wr && !pwdata[`ASP_S_RX_BUF_FULL])) begin
        rx_buf_full <= 1'b0;
      end
      if (rx_fin && rx_buf_full) begin
        overrun_flag <= 1'b1;
      end else if (stat_wr && !pwdata[`ASP_S_OVR]) begin
        overrun_flag <= 1'b0;
      end
      if (rx_fin && !rx_s2) begin
        framing_flag <= 1'b1;
      end else if (stat_wr && !pwdata[`ASP_S_FRM]) begin
        framing_flag <= 1'b0;
      end
      if (rx_fin && par_bad) begin
        parity_err_flag <= 1'b1;
      end else if (stat_wr && !pwdata[`ASP_S_PER]) begin
        parity_err_flag <= 1'b0;
      end
    end
  end

  // Interrupt requests are levels that follow flags and enables
  assign irq.tx_empty_irq = tx_on && tx_buf_empty &&
                            control_reg[`ASP_C_TIE];
  assign irq.tx_end_irq = tx_done_flag &&
                          control_reg[`ASP_C_TX_DONE_IRQ_EN];
  assign irq.rx_full_irq = rx_buf_full && control_reg[`ASP_C_RIE];
  assign irq.rx_err_irq = rx_errs && control_reg[`ASP_C_RIE];

  // ========================================================
  // Assertions
  property p_tbe_off;
    @(posedge clk_sys) disable iff (!rst_n) !tx_on |=> tx_buf_empty;
  endproperty
  a_tbe_off: assert property (p_tbe_off)
    else $error("buffer-empty not set with transmit off");

  property p_rx_keep;
    @(posedge clk_sys) disable iff (!rst_n)
      $fell(rx_on) && !$past(rx_fin) |->
        $stable(rx_holding) && $stable(overrun_flag) && $stable(rx_buf_full);
  endproperty
  a_rx_keep: assert property (p_rx_keep)
    else $error("receive state changed by disabling receiver");

  property p_take;
    @(posedge clk_sys) disable iff (!rst_n)
      tx_st == TX_IDLE && tx_on && !tx_buf_empty |=>
        tx_buf_empty && tx_st == TX_START && tx_shifter == $past(tx_holding);
  endproperty
  a_take: assert property (p_take)
    else $error("holding data not moved to shifter");

  property p_start_low;
    @(posedge clk_sys) disable iff (!rst_n)
      tx_st == TX_START |-> !tx_line_pin;
  endproperty
  a_start_low: assert property (p_start_low)
    else $error("start bit not low");

  property p_end_done;
    @(posedge clk_sys) disable iff (!rst_n)
      tx_end_evt |=> tx_done_flag ##1 (tx_line_pin [*8]);
  endproperty
  a_end_done: assert property (p_end_done)
    else $error("done flag or mark level missing");

  property p_overrun;
    @(posedge clk_sys) disable iff (!rst_n)
      rx_fin && rx_buf_full |=> overrun_flag && $stable(rx_holding);
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged or data overwritten");

  property p_par_err;
    @(posedge clk_sys) disable iff (!rst_n)
      rx_fin && !rx_buf_full && par_bad |=>
        parity_err_flag && rx_holding == $past(rx_data) && !rx_buf_full;
  endproperty
  a_par_err: assert property (p_par_err)
    else $error("parity error handling wrong");

  property p_frame;
    @(posedge clk_sys) disable iff (!rst_n)
      rx_fin && !rx_s2 |=> framing_flag;
  endproperty
  a_frame: assert property (p_frame)
    else $error("framing error not flagged");

  property p_good;
    @(posedge clk_sys) disable iff (!rst_n)
      rx_fin && !rx_buf_full && rx_s2 && !par_bad |=>
        rx_buf_full && rx_holding == $past(rx_data);
  endproperty
  a_good: assert property (p_good)
    else $error("good frame not stored");

  property p_hold_err;
    @(posedge clk_sys) disable iff (!rst_n)
      rx_errs && rx_st == RX_IDLE |=> rx_st == RX_IDLE;
  endproperty
  a_hold_err: assert property (p_hold_err)
    else $error("reception resumed with error set");

  property p_rd_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      rd_en && paddr == `ASP_RXH_OFS && !rx_fin |=> !rx_buf_full;
  endproperty
  a_rd_clear: assert property (p_rd_clear)
    else $error("receive-full not cleared by read");

  c_chain: cover property (@(posedge clk_sys) disable iff (!rst_n)
    tx_end_chk && !tx_buf_empty && tx_on);
  c_overrun: cover property (@(posedge clk_sys) disable iff (!rst_n)
    rx_fin && rx_buf_full);
  c_par_err: cover property (@(posedge clk_sys) disable iff (!rst_n)
    rx_fin && par_bad);

endmodule : asp_uart

/* hdl/asp_params.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define ASP_MODE_OFS 8'h00
`define ASP_CTRL_OFS 8'h04
`define ASP_STAT_OFS 8'h08
`define ASP_TXH_OFS 8'h0c
`define ASP_RXH_OFS 8'h10
`define ASP_BAUD_OFS 8'h14

// ==========================================================
// mode_reg fields
`define ASP_M_SYNC 7
`define ASP_M_SEVEN 6
`define ASP_M_PAR_ON 5
`define ASP_M_PAR_ODD 4
`define ASP_M_TWO_END 3
`define ASP_M_SHORT 2

// ==========================================================
// control_reg fields
`define ASP_C_TIE 7
`define ASP_C_RIE 6
`define ASP_C_TX_ON 5
`define ASP_C_RX_ON 4
`define ASP_C_TX_DONE_IRQ_EN 2
`define ASP_C_SRC_HI 1
`define ASP_C_SRC_LO 0

// ==========================================================
// status_reg fields
`define ASP_S_TBE 7
`define ASP_S_RX_BUF_FULL 6
`define ASP_S_OVR 5
`define ASP_S_FRM 4
`define ASP_S_PER 3
`define ASP_S_TX_DONE_FLAG 2

// ==========================================================
// Reset values and timing
`define ASP_MODE_RST 8'h00
`define ASP_CTRL_RST 8'h00
`define ASP_BAUD_RST 8'h0f
`define ASP_OVS_LAST 4'hf
`define ASP_MID_START 4'h7

`endif

/* hdl/asp_pkg.sv */
// Types shared by the serial port
package asp_pkg;

  // ========================================================
  // Transmit and receive sequencer states, one-hot
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_START = 5'h02,
    TX_DATA = 5'h04,
    TX_PAR = 5'h08,
    TX_END = 5'h10
  } asp_tx_st_t;

  typedef enum logic [4:0] {
    RX_IDLE = 5'h01,
    RX_START = 5'h02,
    RX_DATA = 5'h04,
    RX_PAR = 5'h08,
    RX_END = 5'h10
  } asp_rx_st_t;

  // ========================================================
  // Interrupt request group
  typedef struct packed {
    logic tx_empty_irq;
    logic tx_end_irq;
    logic rx_full_irq;
    logic rx_err_irq;
  } asp_irq_t;

  // Serial clock pin drive: level and active-low enable
  typedef struct packed {
    logic out;
    logic oe_n;
  } asp_pin_drv_t;

endpackage : asp_pkg

/* tb/asp_remote.sv */
// Remote serial transceiver model on the far side of the line
`timescale 1ns/1ps
module asp_remote (
  // Clock
  input wire logic clk_sys,
  // Line
  input wire logic tx_line,
  output logic rx_line
);
  // Baud divider is run at 0 by the bench, so one bit is 16 clocks
  int bit_clks = 16;

  // ========================================================
  // Idle line is pulled high
  initial begin
    rx_line = 1'b1;
  end

  // Send start 0, data LSB first, optional parity, end bits
  task automatic send(input logic [7:0] d, input int nb, input logic pe,
                      input logic pv, input logic ev);
    rx_line <= 1'b0;
    repeat (bit_clks) @(posedge clk_sys);
    for (int i = 0; i < nb; i++) begin
      rx_line <= d[i];
      repeat (bit_clks) @(posedge clk_sys);
    end
    if (pe) begin
      rx_line <= pv;
      repeat (bit_clks) @(posedge clk_sys);
    end
    rx_line <= ev;
    repeat (bit_clks) @(posedge clk_sys);
    rx_line <= 1'b1;
    repeat (bit_clks) @(posedge clk_sys);
  endtask : send

  // Capture nb bits mid-bit after a start edge, then the end bit
  task automatic grab(input int nb, output logic [7:0] d,
                      output logic ev);
    int n;
    n = 0;
    d = 8'h00;
    while (tx_line !== 1'b0 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (bit_clks / 2) @(posedge clk_sys);
    for (int i = 0; i < nb; i++) begin
      repeat (bit_clks) @(posedge clk_sys);
      d[i] = tx_line;
    end
    repeat (bit_clks) @(posedge clk_sys);
    ev = tx_line;
  endtask : grab
endmodule : asp_remote

/* tb/test_async_serial_port.sv */
// Self-checking bench for the serial port
`timescale 1ns/1ps
`include "asp_params.svh"
module test_async_serial_port;
  import asp_pkg::*;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic rx_line_pin, tx_line_pin, slverr;
  logic ext_clk = 1'b0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  asp_pin_drv_t serial_clk_pin;
  asp_irq_t irq;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;

  asp_uart asp_uart_i (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_line_pin(rx_line_pin), .tx_line_pin(tx_line_pin),
    .serial_clk_pin_in(ext_clk), .serial_clk_pin(serial_clk_pin),
    .irq(irq));
  asp_remote asp_remote_i (.clk_sys(clk_sys), .tx_line(tx_line_pin),
    .rx_line(rx_line_pin));

  // ========================================================
  // Clock, and a ceiling so a hang still ends in a verdict
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // External 16x clock runs from time zero, through init
  // Synchronous mode is never selected, so it never needs a quiet clock
  // during init
  always @(posedge clk_sys) ext_clk <= ~ext_clk;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One APB transfer; an idle cycle follows so psel never toggles twice
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rd

  // Transmit in 8, 7 and 5 bit formats; parity bit captured as data
  task automatic t_tx_formats();
    logic [7:0] md [3] = '{8'h00, 8'h40, 8'h24};
    logic [7:0] dt [3] = '{8'ha5, 8'h7f, 8'h15};
    logic [7:0] ex [3] = '{8'ha5, 8'h7f, 8'h35};
    int nb [3] = '{8, 7, 6};
    logic [7:0] d;
    logic ev;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, `ASP_MODE_OFS, {24'h0, md[i]});
      fork
        asp_remote_i.grab(nb[i], d, ev);
        apb(1'b1, `ASP_TXH_OFS, {24'h0, dt[i]});
      join
      chk("tx data", {24'h0, ex[i]}, {24'h0, d});
      chk("tx end", 32'h1, {31'h0, ev});
      rd("tx status", `ASP_STAT_OFS, 32'h84);
    end
    apb(1'b1, `ASP_MODE_OFS, 32'h0);
  endtask : t_tx_formats

  // Clock output drives the pin; external 16x clock paces one frame
  task automatic t_clk_src();
    logic [7:0] d;
    logic ev;
    apb(1'b1, `ASP_CTRL_OFS, 32'h31);
    @(posedge clk_sys);
    chk("clk out oe_n", 32'h0, {31'h0, serial_clk_pin.oe_n});
    apb(1'b1, `ASP_CTRL_OFS, 32'h32);
    @(posedge clk_sys);
    chk("clk in oe_n", 32'h1, {31'h0, serial_clk_pin.oe_n});
    // One external tick every two system clocks
    asp_remote_i.bit_clks = 32;
    fork
      asp_remote_i.grab(8, d, ev);
      apb(1'b1, `ASP_TXH_OFS, 32'h96);
    join
    chk("ext tx data", 32'h96, {24'h0, d});
    chk("ext tx end", 32'h1, {31'h0, ev});
    asp_remote_i.bit_clks = 16;
    apb(1'b1, `ASP_CTRL_OFS, 32'h30);
  endtask : t_clk_src

  // Clean receive, then overrun with the first byte kept
  task automatic t_rx_overrun();
    asp_remote_i.send(8'h3c, 8, 1'b0, 1'b0, 1'b1);
    rd("rx full", `ASP_STAT_OFS, 32'hc4);
    rd("rx data", `ASP_RXH_OFS, 32'h3c);
    rd("rx cleared", `ASP_STAT_OFS, 32'h84);
    asp_remote_i.send(8'h11, 8, 1'b0, 1'b0, 1'b1);
    asp_remote_i.send(8'h22, 8, 1'b0, 1'b0, 1'b1);
    rd("ovr status", `ASP_STAT_OFS, 32'he4);
    rd("ovr data", `ASP_RXH_OFS, 32'h11);
    rd("ovr read", `ASP_STAT_OFS, 32'ha4);
    apb(1'b1, `ASP_STAT_OFS, 32'h0);
  endtask : t_rx_overrun

  // Parity error stores data and then blocks further reception
  task automatic t_rx_parity();
    apb(1'b1, `ASP_MODE_OFS, 32'h20);
    asp_remote_i.send(8'h01, 8, 1'b1, 1'b0, 1'b1);
    rd("par status", `ASP_STAT_OFS, 32'h8c);
    asp_remote_i.send(8'h55, 8, 1'b1, 1'b0, 1'b1);
    rd("par data", `ASP_RXH_OFS, 32'h01);
    rd("par hold", `ASP_STAT_OFS, 32'h8c);
    apb(1'b1, `ASP_STAT_OFS, 32'h0);
    apb(1'b1, `ASP_MODE_OFS, 32'h0);
  endtask : t_rx_parity

  // Framing error, then receive disable leaves flags and data alone
  task automatic t_rx_framing();
    apb(1'b1, `ASP_CTRL_OFS, 32'hf4);
    asp_remote_i.send(8'h7e, 8, 1'b0, 1'b0, 1'b0);
    rd("frm status", `ASP_STAT_OFS, 32'h94);
    chk("irq", 32'hd, {28'h0, irq});
    apb(1'b1, `ASP_CTRL_OFS, 32'h20);
    rd("rx off status", `ASP_STAT_OFS, 32'h94);
    rd("rx off data", `ASP_RXH_OFS, 32'h7e);
    apb(1'b1, `ASP_STAT_OFS, 32'h0);
  endtask : t_rx_framing

  // Second byte waits in holding; dropping transmit enable empties it
  task automatic t_tx_off();
    apb(1'b1, `ASP_TXH_OFS, 32'h12);
    apb(1'b1, `ASP_TXH_OFS, 32'h34);
    rd("tx pending", `ASP_STAT_OFS, 32'h00);
    apb(1'b1, `ASP_CTRL_OFS, 32'h0);
    apb(1'b0, `ASP_STAT_OFS, 32'h0);
    chk("tx off empty", 32'h80, q & 32'h80);
  endtask : t_tx_off

  // ========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd("reset status", `ASP_STAT_OFS, 32'h84);
    chk("mapped err", 32'h0, {31'h0, slverr});
    rd("unmapped", 8'h18, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, slverr});
    apb(1'b1, `ASP_BAUD_OFS, 32'h0);
    apb(1'b1, `ASP_CTRL_OFS, 32'h30);
    t_tx_formats();
    t_clk_src();
    t_rx_overrun();
    t_rx_parity();
    t_rx_framing();
    t_tx_off();
    end_of_test();
  end
endmodule : test_async_serial_port
